// ==== core/mfc_map.svh ====
// register offsets, reset values, limits, codes and timing counts
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MFC_OFS_SRC    8'h00
`define MFC_OFS_TERM   8'h04
`define MFC_OFS_SCALE  8'h08
`define MFC_OFS_OPT    8'h0C
`define MFC_OFS_FMAX   8'h10
`define MFC_OFS_BASE   8'h14
`define MFC_OFS_VMAX   8'h18
`define MFC_OFS_BEND1  8'h1C
`define MFC_OFS_BEND2  8'h20
`define MFC_OFS_CTL    8'h24
`define MFC_OFS_STAT   8'h28
`define MFC_OFS_VOLT   8'h2C
// ----------------------------------------------------------------------
// reset values (frequencies in 0.1 Hz, voltages in 1 V)
// ----------------------------------------------------------------------
`define MFC_RST_SRC    10'h000
`define MFC_RST_TERM   30'h00000000
`define MFC_RST_SCALE  32'h0258_0001
`define MFC_RST_OPT    6'h00
`define MFC_RST_FMAX   16'h0258
`define MFC_RST_BASE   32'h0190_0258
`define MFC_RST_VMAX   16'h0190
`define MFC_RST_BEND   32'h0000_0000
`define MFC_RST_CTL    2'h0
// ----------------------------------------------------------------------
// limits and function codes
// ----------------------------------------------------------------------
`define MFC_FMAX_LO    16'h00FA
`define MFC_FMAX_HI    16'h1388
`define MFC_SRC_PULSE  4'hC
`define MFC_SRC_OPT    4'hB
`define MFC_FN_PULSE   6'h08
`define MFC_FN_SIGN    6'h31
`define MFC_FN_SETSEL  6'h0B
`define MFC_FN_HOLD    6'h06
// ----------------------------------------------------------------------
// pulse gate time: pulses counted per gate equal kilopulses per second
// ----------------------------------------------------------------------
`define MFC_CLK_MHZ    100
`define MFC_GATE_MS    1
`define MFC_GATE_CYC   (`MFC_GATE_MS * `MFC_CLK_MHZ * 1000)
`endif

// ==== core/mfc_pkg.sv ====
// types shared by the frequency/run command front end
package mfc_pkg;
  // one frequency/voltage point of the pattern
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] freq;
  } mfc_vf_pt_t;
  // commanded output of the block
  typedef struct packed {
    logic        run;
    logic        reverse;
    logic [15:0] freq;
  } mfc_cmd_t;
endpackage : mfc_pkg

// ==== core/mfc_top.sv ====
// frequency-command and run-command front end with AXI4-Lite registers
//
// Notes on behaviour
// - source code 12 takes the command from the pulse train, valid only when terminal 5 has code 8.
// - a terminal other than terminal 5 with code 49 carries the sign; with none the sign is positive.
// - +/forward gives forward, +/reverse reverse, -/forward reverse, -/reverse forward.
// - command in hertz equals kilopulses per second times scale hertz over scale rate.
// - the pulse command is low-pass filtered; a larger time constant responds more slowly.
// - with a code 11 terminal, off selects the primary source and on the secondary one.
// - source code 11 takes the command from the option word as 8 bit, 12 bit binary or BCD.
// - run source 0 keypad run with terminal direction, 1 terminals, 2 keypad forward, 3 keypad reverse.
// - writes to the run source are dropped while forward or reverse run is on.
// - with a code 6 terminal on, momentary run inputs are latched; off releases; else 2-wire.
// - maximum frequency accepts only 25.0 to 500.0 Hz and the command never exceeds it.
// - the voltage pattern uses the maximum, base and two bend points.
// - with boost or vector control, maximum voltage and both bend points are ignored.
// - commanded voltage always stays below the measured supply voltage; the code clamps to last cycle's supply minus 1, 0 at supply 0.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mfc_map.svh"
module mfc_top #(
  parameter int GATE_CYCLES = `MFC_GATE_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // terminal pins (asynchronous)
  input wire logic [4:0] digital_terminal_i,
  input wire logic run_forward_in_i,
  input wire logic run_backward_in_i,
  // option card word and measured supply, same clock domain
  input wire logic [15:0] option_word_i,
  input wire logic [15:0] supply_volt_i,
  // commands out
  output mfc_pkg::mfc_cmd_t cmd_o,
  output logic [15:0] volt_cmd_o
);
  import mfc_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // true when any terminal field holds the code
  function automatic logic term_has(input logic [29:0] cfg, input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (cfg[i*6 +: 6] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : term_has

  // true when a terminal holding the code is on
  function automatic logic term_on(input logic [29:0] cfg, input logic [4:0] pins,
                                   input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (cfg[i*6 +: 6] == code && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : term_on

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [6:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [4:0] term_pin;
  logic fwd_pin, rev_pin, pulse_rise;
  // s1 is read only by s2; s3 is the previous s2 for edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      pin_s3_r <= 7'h00;
    end else begin
      pin_s1_r <= {run_backward_in_i, run_forward_in_i, digital_terminal_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end
  assign term_pin = pin_s2_r[4:0];
  assign fwd_pin = pin_s2_r[5];
  assign rev_pin = pin_s2_r[6];
  assign pulse_rise = pin_s2_r[4] & ~pin_s3_r[4];

  // ----------------------------------------------------------------------
  // register file and axi4-lite slave
  // ----------------------------------------------------------------------
  logic [9:0] src_r, src_nxt;
  logic [29:0] term_r, term_nxt;
  logic [31:0] scale_r, scale_nxt, base_r, base_nxt, bend1_r, bend1_nxt, bend2_r, bend2_nxt;
  logic [5:0] opt_r, opt_nxt;
  logic [15:0] fmax_r, fmax_nxt, vmax_r, vmax_nxt;
  logic [1:0] ctl_r, ctl_nxt;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, wmerge;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  mfc_cmd_t cmd_r;
  logic [15:0] volt_r;

  // both address and data held, then one write and a response
  always_comb begin
    src_nxt = src_r;
    term_nxt = term_r;
    scale_nxt = scale_r;
    opt_nxt = opt_r;
    fmax_nxt = fmax_r;
    base_nxt = base_r;
    vmax_nxt = vmax_r;
    bend1_nxt = bend1_r;
    bend2_nxt = bend2_r;
    ctl_nxt = ctl_r;
    aw_got_nxt = aw_got_r | (s_axi_awvalid_i & ~aw_got_r);
    w_got_nxt = w_got_r | (s_axi_wvalid_i & ~w_got_r);
    awaddr_nxt = (s_axi_awvalid_i & ~aw_got_r) ? s_axi_awaddr_i : awaddr_r;
    wdata_nxt = (s_axi_wvalid_i & ~w_got_r) ? s_axi_wdata_i : wdata_r;
    bvalid_nxt = bvalid_r & ~s_axi_bready_i;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r & ~s_axi_rready_i;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    wmerge = 32'h0000_0000;
    if (aw_got_r && w_got_r && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'h0;
      // byte strobes pick new bytes; bytes without a strobe are written as zero
      for (int b = 0; b < 4; b++) begin
        wmerge[b*8 +: 8] = s_axi_wstrb_i[b] ? wdata_r[b*8 +: 8] : 8'h00;
      end
      unique case (awaddr_r[7:2])
        // run source bits 9:8 frozen while run inputs on; bits 7:0 always written
        `MFC_OFS_SRC >> 2: begin
          src_nxt[7:0] = wmerge[7:0];
          if (!fwd_pin && !rev_pin) begin
            src_nxt[9:8] = wmerge[9:8];
          end
        end
        `MFC_OFS_TERM >> 2: term_nxt = wmerge[29:0];
        `MFC_OFS_SCALE >> 2: scale_nxt = wmerge;
        `MFC_OFS_OPT >> 2: opt_nxt = wmerge[5:0];
        `MFC_OFS_FMAX >> 2: begin
          if (wmerge[15:0] >= `MFC_FMAX_LO && wmerge[15:0] <= `MFC_FMAX_HI) begin
            fmax_nxt = wmerge[15:0];
          end
        end
        `MFC_OFS_BASE >> 2: base_nxt = wmerge;
        `MFC_OFS_VMAX >> 2: vmax_nxt = wmerge[15:0];
        `MFC_OFS_BEND1 >> 2: bend1_nxt = wmerge;
        `MFC_OFS_BEND2 >> 2: bend2_nxt = wmerge;
        `MFC_OFS_CTL >> 2: ctl_nxt = wmerge[1:0];
        `MFC_OFS_STAT >> 2, `MFC_OFS_VOLT >> 2: bresp_nxt = 2'h0;
        default: bresp_nxt = 2'h2;
      endcase
    end
    if (s_axi_arvalid_i && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'h0;
      unique case (s_axi_araddr_i[7:2])
        `MFC_OFS_SRC >> 2: rdata_nxt = {22'h000000, src_r};
        `MFC_OFS_TERM >> 2: rdata_nxt = {2'h0, term_r};
        `MFC_OFS_SCALE >> 2: rdata_nxt = scale_r;
        `MFC_OFS_OPT >> 2: rdata_nxt = {26'h0000000, opt_r};
        `MFC_OFS_FMAX >> 2: rdata_nxt = {16'h0000, fmax_r};
        `MFC_OFS_BASE >> 2: rdata_nxt = base_r;
        `MFC_OFS_VMAX >> 2: rdata_nxt = {16'h0000, vmax_r};
        `MFC_OFS_BEND1 >> 2: rdata_nxt = bend1_r;
        `MFC_OFS_BEND2 >> 2: rdata_nxt = bend2_r;
        `MFC_OFS_CTL >> 2: rdata_nxt = {30'h00000000, ctl_r};
        `MFC_OFS_STAT >> 2: rdata_nxt = {14'h0000, cmd_r};
        `MFC_OFS_VOLT >> 2: rdata_nxt = {16'h0000, volt_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = 2'h2;
        end
      endcase
    end
  end

  // registers of the bus group
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      src_r <= `MFC_RST_SRC;
      term_r <= `MFC_RST_TERM;
      scale_r <= `MFC_RST_SCALE;
      opt_r <= `MFC_RST_OPT;
      fmax_r <= `MFC_RST_FMAX;
      base_r <= `MFC_RST_BASE;
      vmax_r <= `MFC_RST_VMAX;
      bend1_r <= `MFC_RST_BEND;
      bend2_r <= `MFC_RST_BEND;
      ctl_r <= `MFC_RST_CTL;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else begin
      src_r <= src_nxt;
      term_r <= term_nxt;
      scale_r <= scale_nxt;
      opt_r <= opt_nxt;
      fmax_r <= fmax_nxt;
      base_r <= base_nxt;
      vmax_r <= vmax_nxt;
      bend1_r <= bend1_nxt;
      bend2_r <= bend2_nxt;
      ctl_r <= ctl_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  // ready only while the channel is free, so each item is taken once
  assign s_axi_awready_o = ~aw_got_r;
  assign s_axi_wready_o = ~w_got_r;
  assign s_axi_arready_o = ~rvalid_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // ----------------------------------------------------------------------
  // pulse train measurement and filter
  // ----------------------------------------------------------------------
  logic [16:0] gate_r, gate_nxt, pcnt_r, pcnt_nxt;
  logic [23:0] filt_r, filt_nxt;
  logic [32:0] pscaled;
  logic [15:0] praw;
  logic pulse_ok;
  // pulse input only with terminal 5 set to the pulse code
  assign pulse_ok = (term_r[29:24] == `MFC_FN_PULSE);
  // rate times scale hertz over scale rate; zero rate gives zero
  assign pscaled = (scale_r[15:0] == 16'h0000) ? 33'h0 :
                   33'((pcnt_r * scale_r[31:16]) / scale_r[15:0]);
  assign praw = (pscaled > 33'(16'hFFFF)) ? 16'hFFFF : pscaled[15:0];

  // counts edges per gate; filter steps once per gate
  always_comb begin
    gate_nxt = gate_r + 17'h1;
    pcnt_nxt = pcnt_r + {16'h0, pulse_rise & pulse_ok};
    filt_nxt = filt_r;
    if (gate_r == 17'(GATE_CYCLES - 1)) begin
      gate_nxt = 17'h0;
      pcnt_nxt = {16'h0, pulse_rise & pulse_ok};
      // first-order step, shift sets the time constant
      filt_nxt = 24'($signed({1'b0, praw, 8'h00}) - $signed({1'b0, filt_r}) >>> opt_r[3:0])
                 + filt_r;
    end
  end

  // registers of the pulse group
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gate_r <= 17'h0;
      pcnt_r <= 17'h0;
      filt_r <= 24'h0;
    end else begin
      gate_r <= gate_nxt;
      pcnt_r <= pcnt_nxt;
      filt_r <= filt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // command selection, run control and voltage pattern
  // ----------------------------------------------------------------------
  logic hold_fwd_r, hold_fwd_nxt, hold_rev_r, hold_rev_nxt;
  logic hold_on, eff_fwd, eff_rev, negative, rev_base, run_req;
  logic [3:0] src_sel;
  logic [15:0] opt_val, fsel, fcmd, vout;
  mfc_vf_pt_t pts [5];
  mfc_vf_pt_t lo_pt, hi_pt;
  logic [31:0] span;

  // 4-digit BCD in 0.1 Hz units
  function automatic logic [15:0] bcd_val(input logic [15:0] w);
    return 16'(w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0]);
  endfunction : bcd_val

  always_comb begin
    // latched run inputs while hold terminal on
    hold_on = term_on(term_r, term_pin, `MFC_FN_HOLD);
    hold_fwd_nxt = hold_on & (fwd_pin | hold_fwd_r) & ~rev_pin;
    hold_rev_nxt = hold_on & (rev_pin | hold_rev_r) & ~fwd_pin;
    eff_fwd = term_has(term_r, `MFC_FN_HOLD) ? hold_fwd_r : fwd_pin;
    eff_rev = term_has(term_r, `MFC_FN_HOLD) ? hold_rev_r : rev_pin;
    // setting-select terminal picks the secondary source
    src_sel = term_on(term_r, term_pin, `MFC_FN_SETSEL) ? src_r[7:4] : src_r[3:0];
    // option word as 8 bit, 12 bit or BCD
    unique case (opt_r[5:4])
      2'h0: opt_val = {8'h00, option_word_i[7:0]};
      2'h1: opt_val = {4'h0, option_word_i[11:0]};
      default: opt_val = bcd_val(option_word_i);
    endcase
    if (src_sel == `MFC_SRC_PULSE && pulse_ok) begin
      fsel = filt_r[23:8];
    end else if (src_sel == `MFC_SRC_OPT) begin
      fsel = opt_val;
    end else begin
      fsel = 16'h0000;
    end
    fcmd = (fsel > fmax_r) ? fmax_r : fsel;
    // sign only from terminals 1 to 4, positive when none
    negative = (src_sel == `MFC_SRC_PULSE) &
               term_on({6'h00, term_r[23:0]}, term_pin, `MFC_FN_SIGN);
    // run source decides run and base direction
    unique case (src_r[9:8])
      2'h0: begin
        run_req = ctl_r[0] & (eff_fwd ^ eff_rev);
        rev_base = eff_rev;
      end
      2'h1: begin
        run_req = eff_fwd ^ eff_rev;
        rev_base = eff_rev;
      end
      2'h2: begin
        run_req = ctl_r[0];
        rev_base = 1'b0;
      end
      default: begin
        run_req = ctl_r[0];
        rev_base = 1'b1;
      end
    endcase
    // points in order bend1, bend2, base, max plus origin
    // boost/vector drops bends and maximum voltage
    pts[0] = '{volt: 16'h0000, freq: 16'h0000};
    pts[1] = bend1_r;
    pts[2] = bend2_r;
    pts[3] = base_r;
    pts[4] = '{volt: ctl_r[1] ? base_r[31:16] : vmax_r, freq: fmax_r};
    lo_pt = pts[0];
    hi_pt = pts[4];
    // nearest active point below and above the command
    for (int p = 1; p < 5; p++) begin
      if ((p > 2 || (pts[p].freq != 16'h0000 && !ctl_r[1])) && pts[p].freq <= fcmd &&
          pts[p].freq >= lo_pt.freq) begin
        lo_pt = pts[p];
      end
      if ((p > 2 || (pts[p].freq != 16'h0000 && !ctl_r[1])) && pts[p].freq > fcmd &&
          pts[p].freq < hi_pt.freq) begin
        hi_pt = pts[p];
      end
    end
    span = 32'(hi_pt.freq - lo_pt.freq);
    if (fcmd >= pts[4].freq || span == 32'h0) begin
      vout = (fcmd >= pts[4].freq) ? pts[4].volt : lo_pt.volt;
    end else begin
      vout = 16'($signed({16'h0, lo_pt.volt}) + ($signed({16'h0, hi_pt.volt}) -
             $signed({16'h0, lo_pt.volt})) * $signed({16'h0, fcmd - lo_pt.freq}) /
             $signed(span));
    end
    if (vout >= supply_volt_i) begin
      vout = (supply_volt_i == 16'h0000) ? 16'h0000 : supply_volt_i - 16'h1;
    end
  end

  // registers of the command group
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_fwd_r <= 1'b0;
      hold_rev_r <= 1'b0;
      cmd_r <= '0;
      volt_r <= 16'h0000;
    end else begin
      hold_fwd_r <= hold_fwd_nxt;
      hold_rev_r <= hold_rev_nxt;
      cmd_r.run <= run_req;
      cmd_r.reverse <= rev_base ^ negative;
      cmd_r.freq <= run_req ? fcmd : 16'h0000;
      volt_r <= run_req ? vout : 16'h0000;
    end
  end
  assign cmd_o = cmd_r;
  assign volt_cmd_o = volt_r;
endmodule : mfc_top

// ==== verif/mfc_monitor.sv ====
// checker for the frequency and run command front end
`timescale 1ns/1ps
module mfc_monitor #(
  parameter int GATE_CYCLES = 100000
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  // supply and commands
  input wire logic [15:0] supply_volt_i,
  input wire mfc_pkg::mfc_cmd_t cmd_o,
  input wire logic [15:0] volt_cmd_o
);
  import mfc_pkg::*;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // bus answers come in bounded time and stand until taken
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
  a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
    $stable(s_axi_bresp_o)) else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
    $stable(s_axi_rdata_o)) else $error("read data dropped");
  // only one write may be under way
  a_one_write: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("second write taken");
  a_error_read: assert property (s_axi_rvalid_o && s_axi_rresp_o != 2'b00 |->
    s_axi_rresp_o == 2'b10 && s_axi_rdata_o == 32'h0) else $error("bad error read");
  a_freq_cap: assert property (cmd_o.freq <= 16'h1388)
    else $error("frequency above ceiling");
  // a stopped drive commands neither frequency nor voltage
  a_stop_quiet: assert property (!cmd_o.run |-> cmd_o.freq == 16'h0 && volt_cmd_o == 16'h0)
    else $error("output while stopped");
  a_volt_clamp: assert property ($stable(supply_volt_i) [*2] |->
    volt_cmd_o == 16'h0 || volt_cmd_o < supply_volt_i) else $error("voltage not below supply");
endmodule : mfc_monitor

// ==== verif/mfc_ctrl_model.sv ====
// external controller driving the pulse, sign, select, hold and run terminals
`timescale 1ns/1ps
module mfc_ctrl_model (
  // clock
  input wire logic clk_i,
  // bench requests: half period of the train, 0 stops it
  input wire logic [7:0] half_i,
  input wire logic [3:0] level_i,
  input wire logic fwd_i,
  input wire logic rev_i,
  // terminal pins
  output logic [4:0] terminal_o,
  output logic fwd_o,
  output logic rev_o
);
  logic [7:0] cnt_r = 8'h00;
  logic pulse_r = 1'b0;
  // pulse train on terminal five
  // a stopped train parks low so no stray edge is counted
  always @(posedge clk_i) begin
    if (half_i == 8'h00) begin
      cnt_r <= 8'h00;
      pulse_r <= 1'b0;
    end else if (cnt_r == half_i - 8'h01) begin
      cnt_r <= 8'h00;
      pulse_r <= ~pulse_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign terminal_o = {pulse_r, level_i};
  // run levels, changed by the bench just after an edge
  assign fwd_o = fwd_i;
  assign rev_o = rev_i;
endmodule : mfc_ctrl_model

// ==== verif/test_motor_freq_command_select.sv ====
// testbench for the frequency and run command front end
`timescale 1ns/1ps
`include "mfc_map.svh"
module test_motor_freq_command_select;
  import mfc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic [31:0] s_axi_rdata_o, rdat, term_all;
  logic [4:0] digital_terminal_i;
  logic run_forward_in_i, run_backward_in_i;
  logic [15:0] option_word_i = 16'h0;
  logic [15:0] supply_volt_i = 16'h01F4;
  logic [15:0] volt_cmd_o;
  mfc_cmd_t cmd_o;
  logic [7:0] half = 8'h00;
  logic [3:0] level = 4'h0;
  logic run_forward_in = 1'b0, run_backward_in = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  always #5 core_clk_i = ~core_clk_i;
  mfc_ctrl_model i_mfc_ctrl_model (.clk_i(core_clk_i), .half_i(half), .level_i(level),
    .fwd_i(run_forward_in), .rev_i(run_backward_in), .terminal_o(digital_terminal_i), .fwd_o(run_forward_in_i),
    .rev_o(run_backward_in_i));
  // short gate so one gate counts pulses per 100 cycles
  mfc_top #(.GATE_CYCLES(100)) i_mfc_top (.*, .s_axi_wstrb_i(4'hF));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle
  // readies are sampled settled at the falling edge; bready raised late on purpose
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(negedge core_clk_i);
      aw = s_axi_awready_o;
      w = s_axi_wready_o;
      @(posedge core_clk_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_awvalid_i || s_axi_wvalid_i);
    idle(2);
    s_axi_bready_i <= 1'b1;
    do @(negedge core_clk_i); while (!s_axi_bvalid_o);
    rsp = s_axi_bresp_o;
    @(posedge core_clk_i);
    s_axi_bready_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do @(negedge core_clk_i); while (!s_axi_arready_o);
    @(posedge core_clk_i);
    s_axi_arvalid_i <= 1'b0;
    s_axi_rready_i <= 1'b1;
    do @(negedge core_clk_i); while (!s_axi_rvalid_o);
    rdat = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
    @(posedge core_clk_i);
    s_axi_rready_i <= 1'b0;
  endtask : rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    term_all = {2'h0, `MFC_FN_PULSE, 12'h000, `MFC_FN_SETSEL, `MFC_FN_SIGN};
    idle(10);
    rst_i <= 1'b0;
    rd(`MFC_OFS_SCALE);
    check(rdat, `MFC_RST_SCALE);
    rd(`MFC_OFS_BASE);
    check(rdat, `MFC_RST_BASE);
    rd(8'h30);
    check(rsp, 2'b10);
    check(rdat, 32'h0);
    wr(8'h30, 32'h1);
    check(rsp, 2'b10);
    for (int i = 0; i < 4; i++) begin
      wr(`MFC_OFS_FMAX, i[0] ? (i[1] ? 32'h1388 : 32'h1389) : (i[1] ? 32'hFA : 32'hF9));
      rd(`MFC_OFS_FMAX);
      check(rdat, i[1] ? (i[0] ? 32'h1388 : 32'hFA) : 32'h258);
    end
    wr(`MFC_OFS_FMAX, 32'h258);
    $display("test registers done");
    // sign and run give direction, 10 pulses per gate
    wr(`MFC_OFS_TERM, term_all);
    wr(`MFC_OFS_SCALE, 32'h001E_0002);
    wr(`MFC_OFS_SRC, 32'h1BC);
    half <= 8'h05;
    for (int i = 0; i < 4; i++) begin
      level[0] <= i[1];
      run_forward_in <= !i[0];
      run_backward_in <= i[0];
      idle(400);
      check({cmd_o.run, cmd_o.reverse}, {1'b1, i[1] ^ i[0]});
      check(cmd_o.freq, 16'h96);
    end
    run_forward_in <= 1'b1;
    run_backward_in <= 1'b0;
    level <= 4'h0;
    wr(`MFC_OFS_SCALE, 32'h001E_0001);
    wr(`MFC_OFS_FMAX, 32'hFA);
    idle(400);
    check(cmd_o.freq, 16'hFA);
    wr(`MFC_OFS_FMAX, 32'h258);
    wr(`MFC_OFS_SCALE, 32'h001E_0002);
    $display("test pulse done");
    // select terminal picks the option word in each format
    option_word_i <= 16'h0123;
    level[1] <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      wr(`MFC_OFS_OPT, f << 4);
      idle(20);
      check(cmd_o.freq, f == 0 ? 16'h23 : (f == 1 ? 16'h123 : 16'h7B));
    end
    level[1] <= 1'b0;
    wr(`MFC_OFS_OPT, 32'h3);
    // run source frozen while a run input is on
    wr(`MFC_OFS_SRC, 32'h3BC);
    rd(`MFC_OFS_SRC);
    check(rdat, 32'h1BC);
    // slow filter still holds part of the old command
    idle(300);
    half <= 8'h00;
    idle(250);
    check(cmd_o.freq > 16'h0 && cmd_o.freq < 16'h96, 1'b1);
    wr(`MFC_OFS_OPT, 32'h0);
    half <= 8'h05;
    // run inputs off before terminals are reassigned
    run_forward_in <= 1'b0;
    idle(5);
    // without a sign terminal the polarity is positive
    wr(`MFC_OFS_TERM, term_all & 32'hFFFF_FFC0);
    level[0] <= 1'b1;
    run_backward_in <= 1'b1;
    idle(400);
    check(cmd_o.reverse, 1'b1);
    // pulse train unusable without its terminal code
    wr(`MFC_OFS_TERM, term_all & 32'h00FF_FFC0);
    idle(400);
    check(cmd_o.freq, 16'h0);
    run_backward_in <= 1'b0;
    idle(5);
    // hold latches a momentary run and releases it
    wr(`MFC_OFS_TERM, term_all | {14'h0, `MFC_FN_HOLD, 12'h0});
    level <= 4'h4;
    run_forward_in <= 1'b1;
    idle(5);
    run_forward_in <= 1'b0;
    idle(10);
    check(cmd_o.run, 1'b1);
    level <= 4'h0;
    idle(10);
    check(cmd_o.run, 1'b0);
    $display("test terminals done");
    // every run source, option word 45.0 Hz
    half <= 8'h00;
    option_word_i <= 16'h01C2;
    wr(`MFC_OFS_OPT, 32'h10);
    wr(`MFC_OFS_CTL, 32'h1);
    wr(`MFC_OFS_TERM, term_all);
    for (int m = 0; m < 4; m++) begin
      wr(`MFC_OFS_SRC, {22'h0, m[1:0], 8'h0B});
      run_backward_in <= (m == 0);
      run_forward_in <= (m == 1);
      idle(20);
      check({cmd_o.run, cmd_o.reverse}, {1'b1, m == 0 || m == 3});
      run_forward_in <= 1'b0;
      run_backward_in <= 1'b0;
      idle(5);
    end
    wr(`MFC_OFS_SRC, 32'h20B);
    idle(20);
    check(volt_cmd_o, 16'h12C);
    wr(`MFC_OFS_BEND1, 32'h0064_012C);
    idle(20);
    check(volt_cmd_o, 16'hFA);
    wr(`MFC_OFS_CTL, 32'h3);
    idle(20);
    check(volt_cmd_o, 16'h12C);
    supply_volt_i <= 16'hC8;
    idle(20);
    check(volt_cmd_o, 16'hC7);
    $display("test voltage done");
    summarize();
  end
  // watchdog well beyond the expected run
  initial begin
    idle(30000);
    mismatches++;
    summarize();
  end
endmodule : test_motor_freq_command_select
bind mfc_top mfc_monitor #(.GATE_CYCLES(GATE_CYCLES)) i_mfc_monitor (.*);
